// [hdl/des_event_status.sv]
// dma event status flags with avalon-mm register access
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "des_params.svh"
module des_event_status
    import des_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [`DES_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`DES_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [`DES_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // level events from mac and dma engines
    input wire logic link_up,
    input wire logic tx_frame_sent,
    input wire logic rx_frame_ready,
    input wire logic tx_dma_stopped,
    input wire logic rx_dma_stopped,
    // descriptor fetch strobes and ownership, start commands, rx frame recognized
    input wire logic tx_desc_fetch,
    input wire logic tx_desc_host_owned,
    input wire logic tx_start_cmd,
    input wire logic rx_desc_fetch,
    input wire logic rx_desc_host_owned,
    input wire logic rx_start_cmd,
    input wire logic rx_frame_recognized,
    // status out
    output logic tx_suspend,
    output logic rx_suspend,
    output logic irq
);
    des_state_type state, next_state;
    logic [`DES_FLAG_W-1:0] flags, next_flags, enable;
    logic [`DES_FLAG_W-1:0] set_vec, clr_vec;
    logic rx_prev_dev_owned;
    logic [`DES_LEVEL_W-1:0] lvl_in, lvl_rise, lvl_fall;

    // bus decode
    wire req = avs_read | avs_write;
    wire in_ack = (state == des_ack);
    wire wr_accept = in_ack & avs_write;
    wire rd_accept = in_ack & avs_read;
    wire hit_status = (avs_address == `DES_STATUS_OFS);
    wire hit_enable = (avs_address == `DES_ENABLE_OFS);
    wire lane_hi = avs_byteenable[`DES_FLAG_LANE];
    wire [`DES_FLAG_W-1:0] wr_bits =
        avs_writedata[`DES_FLAG_MSB:`DES_FLAG_LSB];

    // one wait state per access so read data come from a flop
    assign avs_waitrequest = req & ~in_ack;
    assign next_state = (state == des_idle && req) ? des_ack : des_idle;

    // level inputs: stopped states, done strobes, link
    assign lvl_in = {link_up, tx_frame_sent, rx_frame_ready,
                     tx_dma_stopped, rx_dma_stopped};

    des_edge_detect #(
        .WIDTH(`DES_LEVEL_W)
    ) u_edges (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .level(lvl_in),
        .rise(lvl_rise),
        .fall(lvl_fall)
    );

    wire tx_unavail_ev = tx_desc_fetch & tx_desc_host_owned;
    // only the first host-owned fetch after a device-owned one counts
    wire rx_host_fetch = rx_desc_fetch & rx_desc_host_owned;
    wire rx_unavail_ev = rx_host_fetch & rx_prev_dev_owned;

    assign set_vec[`DES_IDX_LINK] = lvl_rise[4] | lvl_fall[4];
    assign set_vec[`DES_IDX_TXD] = lvl_rise[3];
    assign set_vec[`DES_IDX_RXD] = lvl_rise[2];
    assign set_vec[`DES_IDX_TXU] = tx_unavail_ev;
    assign set_vec[`DES_IDX_RXU] = rx_unavail_ev;
    assign set_vec[`DES_IDX_TXS] = lvl_rise[1];
    assign set_vec[`DES_IDX_RXS] = lvl_rise[0];

    // write one clears, zero leaves the bit; reads never clear
    assign clr_vec = (wr_accept & hit_status & lane_hi) ?
        wr_bits : '0;
    // set applied after clear so a coincident event survives
    assign next_flags = (flags & ~clr_vec) | set_vec;

    wire [`DES_DATA_W-1:0] rd_status =
        {flags, {`DES_FLAG_LSB{1'b0}}};
    wire [`DES_DATA_W-1:0] rd_enable =
        {enable, {`DES_FLAG_LSB{1'b0}}};
    wire [`DES_DATA_W-1:0] rd_mux = hit_status ? rd_status :
        (hit_enable ? rd_enable : 32'h0000_0000);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= des_idle;
            avs_readdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            if (state == des_idle && avs_read) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flags <= `DES_FLAG_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            enable <= `DES_ENABLE_RESET;
        end else if (wr_accept && hit_enable && lane_hi) begin
            enable <= wr_bits;
        end
    end

    // registered so the interrupt line never glitches
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & enable);
        end
    end

    // transmit waits for software's start command alone; it is up to
    // software to have returned the descriptor first
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_suspend <= 1'b0;
        end else if (tx_unavail_ev) begin
            tx_suspend <= 1'b1;
        end else if (tx_start_cmd) begin
            tx_suspend <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_suspend <= 1'b0;
        end else if (rx_host_fetch) begin
            rx_suspend <= 1'b1;
        end else if (rx_start_cmd || rx_frame_recognized) begin
            rx_suspend <= 1'b0;
        end
    end

    // last fetched receive descriptor ownership, device-owned at start
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_prev_dev_owned <= 1'b1;
        end else if (rx_desc_fetch) begin
            rx_prev_dev_owned <= ~rx_desc_host_owned;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_status_write(int idx);
        wr_accept && hit_status && lane_hi && wr_bits[idx];
    endsequence

    sequence s_status_write_zero(int idx);
        wr_accept && hit_status && !wr_bits[idx];
    endsequence

    a_tx_done_set: assert property (
        lvl_rise[3] |=> flags[`DES_IDX_TXD])
        else $error("tx done flag not set after frame sent");

    a_w1c_clear: assert property (
        s_status_write(`DES_IDX_RXD) and !set_vec[`DES_IDX_RXD]
        |=> !flags[`DES_IDX_RXD])
        else $error("write one did not clear rx done flag");

    a_zero_write_keeps: assert property (
        flags[`DES_IDX_LINK] ##0 s_status_write_zero(`DES_IDX_LINK)
        |=> flags[`DES_IDX_LINK])
        else $error("zero write changed link flag");

    a_rx_done_set: assert property (
        lvl_rise[2] |=> flags[`DES_IDX_RXD])
        else $error("rx done flag not set after frame ready");

    a_tx_unavail_suspend: assert property (
        tx_desc_fetch && tx_desc_host_owned
        |=> flags[`DES_IDX_TXU] && tx_suspend)
        else $error("tx unavailable not flagged or not suspended");

    a_tx_resume_start: assert property (
        tx_suspend && tx_start_cmd && !tx_desc_fetch |=> !tx_suspend)
        else $error("tx did not resume on start command");

    a_rx_unavail_first: assert property (
        rx_desc_fetch && rx_desc_host_owned && rx_prev_dev_owned
        |=> flags[`DES_IDX_RXU] && rx_suspend)
        else $error("rx unavailable not flagged on first host fetch");

    a_rx_resume_frame: assert property (
        rx_suspend && (rx_start_cmd || rx_frame_recognized)
        && !rx_desc_fetch |=> !rx_suspend)
        else $error("rx did not resume");

    a_rx_unavail_once: assert property (
        rx_desc_fetch && rx_desc_host_owned && !rx_prev_dev_owned
        && !flags[`DES_IDX_RXU] |=> !flags[`DES_IDX_RXU])
        else $error("rx unavailable asserted again on repeat fetch");

    a_tx_stop_set: assert property (
        $rose(tx_dma_stopped) ##1 tx_dma_stopped
        |=> flags[`DES_IDX_TXS] || $past(clr_vec[`DES_IDX_TXS]))
        else $error("tx stopped flag missing");

    a_rx_stop_set: assert property (
        lvl_rise[0] |=> flags[`DES_IDX_RXS])
        else $error("rx stopped flag missing");

    a_link_change_set: assert property (
        (lvl_rise[4] || lvl_fall[4]) |=> flags[`DES_IDX_LINK])
        else $error("link change flag missing");

    a_irq_gate_mask: assert property (
        ##1 irq == $past(|(flags & enable)))
        else $error("irq does not follow masked flags");

    a_read_no_clear: assert property (
        rd_accept && !wr_accept |=> (flags & $past(flags)) == $past(flags))
        else $error("read cleared a flag");

    a_reserved_zero: assert property (
        rd_accept && hit_status |-> avs_readdata[24:0] == 25'h0000000)
        else $error("reserved status bits not zero");

    a_set_wins_clear: assert property (
        s_status_write(`DES_IDX_TXD) and set_vec[`DES_IDX_TXD]
        |=> flags[`DES_IDX_TXD])
        else $error("event lost against clear");

    a_bus_one_wait: assert property (
        state == des_idle && req |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus access not answered after one wait");
endmodule // des_event_status

// [hdl/des_params.svh]
// constants for the dma event status block
`ifndef DES_PARAMS_SVH
`define DES_PARAMS_SVH

`define DES_ADDR_W 8
`define DES_DATA_W 32
`define DES_STATUS_OFS 8'h2C
`define DES_ENABLE_OFS 8'h28
`define DES_FLAG_LSB 25
`define DES_FLAG_MSB 31
`define DES_FLAG_W 7
`define DES_FLAG_RESET 7'h00
`define DES_ENABLE_RESET 7'h00
`define DES_FLAG_LANE 3
`define DES_IDX_LINK 6
`define DES_IDX_TXD 5
`define DES_IDX_RXD 4
`define DES_IDX_TXU 3
`define DES_IDX_RXU 2
`define DES_IDX_TXS 1
`define DES_IDX_RXS 0
`define DES_LEVEL_W 5

`endif

// [hdl/des_pkg.sv]
// types shared by the dma event status block
package des_pkg;
    typedef enum logic [1:0] {
        des_idle = 2'b01,
        des_ack = 2'b10
    } des_state_type;
endpackage

// [hdl/des_edge_detect.sv]
// edge detector bank for level event inputs
`timescale 1ns/1ps
module des_edge_detect #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // levels in, edge pulses out
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev;
    logic armed;

    // first cycle after reset only samples, so a level high in reset
    // is not mistaken for an edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev <= '0;
            armed <= 1'b0;
        end else begin
            prev <= level;
            armed <= 1'b1;
        end
    end

    assign rise = armed ? (level & ~prev) : '0;
    assign fall = armed ? (~level & prev) : '0;
endmodule // des_edge_detect

// [testbench/des_host_model.sv]
// host cpu model: avalon-mm master for the event status block
`timescale 1ns/1ps
`include "des_params.svh"
module des_host_model (
    // clock
    input wire logic sys_clk,
    // avalon-mm master
    output logic [`DES_ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [`DES_DATA_W-1:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [`DES_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
    end

    // one word; clears are write-one, never read-modify-write
    task automatic access(input logic wr, input logic [7:0] a,
            input logic [31:0] d, input logic [3:0] be,
            output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released lines must not look like the last request
        avs_address <= ~a;
        avs_writedata <= ~d;
    endtask
endmodule // des_host_model

// [testbench/des_event_status_tb_top.sv]
// self-checking bench for the dma event status block
`timescale 1ns/1ps
`include "des_params.svh"
module des_event_status_tb_top;
    logic sys_clk, nrst, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, exp;
    logic [3:0] avs_byteenable;
    logic [4:0] ev;
    logic [2:0] cmd;
    logic tx_desc_fetch, tx_desc_host_owned, rx_desc_fetch;
    logic rx_desc_host_owned, tx_suspend, rx_suspend, irq;
    int failures = 0, n_tests = 0, cycles = 0;
    int pos [5] = '{25, 26, 29, 30, 31};
    localparam logic [7:0] ST = `DES_STATUS_OFS;
    localparam logic [7:0] EN = `DES_ENABLE_OFS;

    des_host_model i_des_host_model (.sys_clk(sys_clk),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    des_event_status i_des_event_status (.sys_clk(sys_clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link_up(ev[4]),
        .tx_frame_sent(ev[3]), .rx_frame_ready(ev[2]),
        .tx_dma_stopped(ev[1]), .rx_dma_stopped(ev[0]),
        .tx_desc_fetch(tx_desc_fetch),
        .tx_desc_host_owned(tx_desc_host_owned), .tx_start_cmd(cmd[0]),
        .rx_desc_fetch(rx_desc_fetch),
        .rx_desc_host_owned(rx_desc_host_owned), .rx_start_cmd(cmd[1]),
        .rx_frame_recognized(cmd[2]), .tx_suspend(tx_suspend),
        .rx_suspend(rx_suspend), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        i_des_host_model.access(1'b1, a, d, be, q);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] want);
        i_des_host_model.access(1'b0, a, 32'h0, 4'hF, q);
        check(q, want);
    endtask

    // flag lands one cycle after the edge, irq one more
    task settle();
        repeat (3) @(posedge sys_clk);
    endtask

    task pulse(input int k);
        @(posedge sys_clk) cmd[k] <= 1'b1;
        @(posedge sys_clk) cmd[k] <= 1'b0;
        settle();
    endtask

    task fetch(input logic tx, input logic host);
        @(posedge sys_clk) begin
            tx_desc_fetch <= tx;
            rx_desc_fetch <= !tx;
            tx_desc_host_owned <= host;
            rx_desc_host_owned <= host;
        end
        // ownership handed back before any start command
        @(posedge sys_clk) begin
            tx_desc_fetch <= 1'b0;
            rx_desc_fetch <= 1'b0;
            tx_desc_host_owned <= 1'b0;
            rx_desc_host_owned <= 1'b0;
        end
        settle();
    endtask

    task print_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        nrst = 1'b0;
        {ev, cmd, tx_desc_fetch, tx_desc_host_owned} = '0;
        {rx_desc_fetch, rx_desc_host_owned} = '0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rd_chk(ST, 32'h0);
        rd_chk(EN, 32'h0);
        wr(EN, 32'hFFFF_FFFF, 4'hF);
        rd_chk(EN, 32'hFE00_0000);
        wr(EN, 32'h0, 4'hF);
        wr(8'h30, 32'hFFFF_FFFF, 4'hF);
        rd_chk(8'h30, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk) ev[i] <= 1'b1;
            settle();
            exp = 32'h1 << pos[i];
            rd_chk(ST, exp);
            rd_chk(ST, exp);
            check({31'h0, irq}, 32'h0);
            wr(ST, 32'h0, 4'hF);
            wr(ST, 32'hFFFF_FFFF, 4'h7);
            rd_chk(ST, exp);
            wr(ST, 32'hFFFF_FFFF, 4'hF);
            rd_chk(ST, 32'h0);
            @(posedge sys_clk) ev[i] <= 1'b0;
            settle();
            rd_chk(ST, (i == 4) ? exp : 32'h0);
            wr(ST, exp, 4'hF);
        end
        $display("test event flags done");
        // edge lands in the very cycle the clear is accepted
        fork
            wr(ST, 32'h4000_0000, 4'hF);
            begin
                repeat (2) @(posedge sys_clk);
                ev[3] <= 1'b1;
            end
        join
        rd_chk(ST, 32'h4000_0000);
        @(posedge sys_clk) ev[3] <= 1'b0;
        settle();
        wr(ST, 32'h4000_0000, 4'hF);
        rd_chk(ST, 32'h0);
        $display("test set over clear done");
        wr(EN, 32'h4000_0000, 4'hF);
        @(posedge sys_clk) ev[1] <= 1'b1;
        settle();
        check({31'h0, irq}, 32'h0);
        @(posedge sys_clk) ev[3] <= 1'b1;
        settle();
        check({31'h0, irq}, 32'h1);
        wr(ST, 32'h4000_0000, 4'hF);
        settle();
        check({31'h0, irq}, 32'h0);
        rd_chk(ST, 32'h0400_0000);
        wr(ST, 32'hFFFF_FFFF, 4'hF);
        $display("test irq mask done");
        fetch(1'b1, 1'b1);
        check({31'h0, tx_suspend}, 32'h1);
        rd_chk(ST, 32'h1000_0000);
        pulse(0);
        check({31'h0, tx_suspend}, 32'h0);
        wr(ST, 32'h1000_0000, 4'hF);
        fetch(1'b0, 1'b1);
        check({31'h0, rx_suspend}, 32'h1);
        rd_chk(ST, 32'h0800_0000);
        wr(ST, 32'h0800_0000, 4'hF);
        fetch(1'b0, 1'b1);
        rd_chk(ST, 32'h0);
        pulse(2);
        check({31'h0, rx_suspend}, 32'h0);
        fetch(1'b0, 1'b0);
        fetch(1'b0, 1'b1);
        rd_chk(ST, 32'h0800_0000);
        pulse(1);
        check({31'h0, rx_suspend}, 32'h0);
        $display("test descriptors done");
        print_verdict();
    end
endmodule // des_event_status_tb_top
